// ===== inc/tpc_pkg.sv
// Shared constants and types for the transmitter configuration register bank
package tpc_pkg;

    // Register byte offsets on the register bus
    localparam logic [11:0] OFS_LINE_START_WAIT = 12'h1cc;
    localparam logic [11:0] OFS_PHY_HOLD_RESET = 12'h200;
    localparam logic [11:0] OFS_TX_EMPHASIS_LANE0 = 12'h210;
    localparam logic [11:0] OFS_TX_EMPHASIS_LANE1 = 12'h214;
    localparam logic [11:0] OFS_TX_EMPHASIS_LANE2 = 12'h218;
    localparam logic [11:0] OFS_TX_EMPHASIS_LANE3 = 12'h21c;
    localparam logic [11:0] OFS_TX_SWING_LANE0 = 12'h220;
    localparam logic [11:0] OFS_TX_SWING_LANE1 = 12'h224;
    localparam logic [11:0] OFS_TX_SWING_LANE2 = 12'h228;
    localparam logic [11:0] OFS_TX_SWING_LANE3 = 12'h22c;
    localparam logic [11:0] OFS_PRBS_TEST_PATTERN_ENABLE = 12'h230;

    // Storage slot of each register
    localparam int NUM_REGS = 11;
    localparam logic [3:0] IDX_LINE_WAIT = 4'h0;
    localparam logic [3:0] IDX_HOLD = 4'h1;
    localparam logic [3:0] IDX_EMPH0 = 4'h2;
    localparam logic [3:0] IDX_EMPH1 = 4'h3;
    localparam logic [3:0] IDX_EMPH2 = 4'h4;
    localparam logic [3:0] IDX_EMPH3 = 4'h5;
    localparam logic [3:0] IDX_SWING0 = 4'h6;
    localparam logic [3:0] IDX_SWING1 = 4'h7;
    localparam logic [3:0] IDX_SWING2 = 4'h8;
    localparam logic [3:0] IDX_SWING3 = 4'h9;
    localparam logic [3:0] IDX_PRBS = 4'ha;
    localparam logic [3:0] IDX_NONE = 4'hf;

    // Field positions
    localparam int WAIT_MSB = 7;
    localparam int HOLD_BIT = 0;
    localparam int LEVEL_MSB = 2;
    localparam int PRBS_EN_BIT = 0;

    // Reset values
    localparam logic [31:0] REG_RESET = 32'h0;
    localparam logic [6:0] PRBS_SEED = 7'h7f;

    // Feedback taps of x^7 + x^6 + 1
    localparam int PRBS_TAP_HI = 6;
    localparam int PRBS_TAP_LO = 5;

    // Bus encodings
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic HRESP_OKAY = 1'b0;

    // Line-start wait sequencer states
    typedef enum logic [0:0] {
        WAIT_IDLE,
        WAIT_COUNT
    } tpc_wait_state_t;

endpackage : tpc_pkg

// ===== logic/tpc_config_regs.sv
// Transmitter configuration register bank with AHB-Lite slave port
//
// Contract
// - New line waits programmed cycles before data
// - Hold bit one keeps transmitter in reset
// - Per-lane three-bit pre-emphasis level to lane
// - Per-lane three-bit voltage swing level to lane
// - Level codes pass through to transmitter unchanged
// - Enable bit sends seven-bit pseudo-random pattern
//
// Decided for this implementation: the AHB-Lite slave port.
module tpc_config_regs
    import tpc_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic LINE_START,
    output logic LINE_WAIT_BUSY,
    output logic LINE_DATA_GO,
    output logic TRANSMITTER_HOLD_IN_RESET,
    output logic [2:0] LANE0_EMPHASIS_LEVEL,
    output logic [2:0] LANE1_EMPHASIS_LEVEL,
    output logic [2:0] LANE2_EMPHASIS_LEVEL,
    output logic [2:0] LANE3_EMPHASIS_LEVEL,
    output logic [2:0] LANE0_SWING_LEVEL,
    output logic [2:0] LANE1_SWING_LEVEL,
    output logic [2:0] LANE2_SWING_LEVEL,
    output logic [2:0] LANE3_SWING_LEVEL,
    output logic PRBS_TEST_PATTERN_ON,
    output logic PRBS_BIT
);

    // Map a byte offset to its storage slot, IDX_NONE when unmapped
    function automatic logic [3:0] tpc_decode(input logic [11:0] ofs);
        logic [3:0] idx;
        idx = IDX_NONE;
        case (ofs)
            OFS_LINE_START_WAIT: idx = IDX_LINE_WAIT;
            OFS_PHY_HOLD_RESET: idx = IDX_HOLD;
            OFS_TX_EMPHASIS_LANE0: idx = IDX_EMPH0;
            OFS_TX_EMPHASIS_LANE1: idx = IDX_EMPH1;
            OFS_TX_EMPHASIS_LANE2: idx = IDX_EMPH2;
            OFS_TX_EMPHASIS_LANE3: idx = IDX_EMPH3;
            OFS_TX_SWING_LANE0: idx = IDX_SWING0;
            OFS_TX_SWING_LANE1: idx = IDX_SWING1;
            OFS_TX_SWING_LANE2: idx = IDX_SWING2;
            OFS_TX_SWING_LANE3: idx = IDX_SWING3;
            OFS_PRBS_TEST_PATTERN_ENABLE: idx = IDX_PRBS;
            default: idx = IDX_NONE;
        endcase
        return idx;
    endfunction : tpc_decode

    // Whether a slot number names a real register
    function automatic logic tpc_is_mapped(input logic [3:0] idx);
        return idx != IDX_NONE;
    endfunction : tpc_is_mapped

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------

    // Full words are kept so a read returns exactly what was written
    logic [31:0] regs [0:NUM_REGS-1];

    // ------------------------------------------------------------
    // Bus address phase
    // ------------------------------------------------------------

    // Transfer accepted this edge (NONSEQ or SEQ, slave selected)
    wire addr_take;
    // Slot of the address on the bus
    wire [3:0] addr_idx;
    // Address falls on a register
    wire addr_hit;
    // Read accepted this edge
    wire rd_take;
    // Write accepted this edge, to a real register
    wire wr_take;

    // Only the byte offset inside the 4 KB window is decoded
    assign addr_take = HSEL & HREADY & HTRANS[1];
    assign addr_idx = tpc_decode(HADDR[11:0]);
    assign addr_hit = tpc_is_mapped(addr_idx);
    assign rd_take = addr_take & ~HWRITE;
    assign wr_take = addr_take & HWRITE & addr_hit;

    // ------------------------------------------------------------
    // Bus data phase state
    // ------------------------------------------------------------

    // A write is in its data phase
    logic wr_pend;
    // Slot that the pending write targets
    logic [3:0] wr_idx;

    // Capture write address phase; only advance when the bus moves
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            wr_pend <= 1'b0;
            wr_idx <= IDX_NONE;
        end else if (HREADY) begin
            wr_pend <= wr_take;
            wr_idx <= addr_idx;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------

    // Pending write lands at the same edge the read is sampled
    wire wr_forward;
    // Safe slot for array selection
    wire [3:0] rd_sel;
    // Stored word at the read address
    wire [31:0] rd_word;
    // Value loaded into the read data flop
    wire [31:0] next_rdata;

    // Forwarding avoids returning stale data on write-then-read
    assign wr_forward = wr_pend & (wr_idx == addr_idx);
    assign rd_sel = addr_hit ? addr_idx : IDX_LINE_WAIT;
    assign rd_word = addr_hit ? regs[rd_sel] : REG_RESET;
    assign next_rdata = wr_forward ? HWDATA : rd_word;

    // Read data is built in the address phase so it sits in a flop
    // by the data phase; zero wait states for every transfer
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            HRDATA <= REG_RESET;
        end else if (rd_take) begin
            HRDATA <= next_rdata;
        end else if (HREADY) begin
            // Park at zero outside read data phases
            HRDATA <= REG_RESET;
        end
    end

    // Always ready, always OKAY; unmapped reads give zero
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            HREADYOUT <= 1'b1;
            HRESP <= HRESP_OKAY;
        end else begin
            HREADYOUT <= 1'b1;
            HRESP <= HRESP_OKAY;
        end
    end

    // ------------------------------------------------------------
    // Register write
    // ------------------------------------------------------------

    // Data phase completes on this edge
    wire wr_commit;

    assign wr_commit = wr_pend & HREADY;

    // Whole-word update; byte lanes are not split since only words move
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs[i] <= REG_RESET;
            end
        end else if (wr_commit) begin
            regs[wr_idx] <= HWDATA;
        end
    end

    // ------------------------------------------------------------
    // Transmitter controls
    // ------------------------------------------------------------

    // Hold bit drives the transmitter reset directly
    assign TRANSMITTER_HOLD_IN_RESET = regs[IDX_HOLD][HOLD_BIT];

    // Level codes leave untouched; mapping to drive is the lane's job
    assign LANE0_EMPHASIS_LEVEL = regs[IDX_EMPH0][LEVEL_MSB:0];
    assign LANE1_EMPHASIS_LEVEL = regs[IDX_EMPH1][LEVEL_MSB:0];
    assign LANE2_EMPHASIS_LEVEL = regs[IDX_EMPH2][LEVEL_MSB:0];
    assign LANE3_EMPHASIS_LEVEL = regs[IDX_EMPH3][LEVEL_MSB:0];

    // Swing codes, same layout on all four lanes
    assign LANE0_SWING_LEVEL = regs[IDX_SWING0][LEVEL_MSB:0];
    assign LANE1_SWING_LEVEL = regs[IDX_SWING1][LEVEL_MSB:0];
    assign LANE2_SWING_LEVEL = regs[IDX_SWING2][LEVEL_MSB:0];
    assign LANE3_SWING_LEVEL = regs[IDX_SWING3][LEVEL_MSB:0];

    // Test pattern mode flag to the lane muxes
    assign PRBS_TEST_PATTERN_ON = regs[IDX_PRBS][PRBS_EN_BIT];

    // ------------------------------------------------------------
    // Test pattern source
    // ------------------------------------------------------------

    // Generator halts while the transmitter is held in reset
    tpc_prbs7_gen u_prbs (
        .clk(REF_CLK),
        .rst_n(RESET_N),
        .enable(regs[IDX_PRBS][PRBS_EN_BIT]),
        .hold(regs[IDX_HOLD][HOLD_BIT]),
        .bit_out(PRBS_BIT)
    );

    // ------------------------------------------------------------
    // Line-start wait sequencer
    // ------------------------------------------------------------

    // Programmed wait in cycles; software sizes it from the transfer
    // unit so the input FIFO has filled before data flows
    wire [7:0] wait_cycles;

    assign wait_cycles = regs[IDX_LINE_WAIT][WAIT_MSB:0];

    // Sequencer state
    tpc_wait_state_t state;
    // Next sequencer state
    tpc_wait_state_t next_state;
    // Cycles still to idle
    logic [7:0] wait_count;
    // Next remaining count
    logic [7:0] next_wait_count;
    // Next busy level
    logic next_busy;
    // Next release pulse
    logic next_go;

    // Count down the idle period; a new line restarts it at once
    always_comb begin
        next_state = state;
        next_wait_count = wait_count;
        next_busy = LINE_WAIT_BUSY;
        next_go = 1'b0;
        if (LINE_START) begin
            if (wait_cycles == 8'h00) begin
                // No wait: release on the following cycle
                next_state = WAIT_IDLE;
                next_wait_count = 8'h00;
                next_busy = 1'b0;
                next_go = 1'b1;
            end else begin
                // Idle exactly wait_cycles cycles
                next_state = WAIT_COUNT;
                next_wait_count = wait_cycles;
                next_busy = 1'b1;
            end
        end else begin
            unique case (state)
                WAIT_IDLE: begin
                    // Nothing to do until the next line
                    next_busy = 1'b0;
                end
                WAIT_COUNT: begin
                    if (wait_count == 8'h01) begin
                        // Last idle cycle ends; data may start
                        next_state = WAIT_IDLE;
                        next_wait_count = 8'h00;
                        next_busy = 1'b0;
                        next_go = 1'b1;
                    end else begin
                        // Keep holding the framing logic
                        next_wait_count = wait_count - 8'h01;
                        next_busy = 1'b1;
                    end
                end
            endcase
        end
    end

    // Sequencer flops; outputs come straight from here
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            state <= WAIT_IDLE;
            wait_count <= 8'h00;
            LINE_WAIT_BUSY <= 1'b0;
            LINE_DATA_GO <= 1'b0;
        end else begin
            state <= next_state;
            wait_count <= next_wait_count;
            LINE_WAIT_BUSY <= next_busy;
            LINE_DATA_GO <= next_go;
        end
    end

    // HSIZE and upper address bits are not decoded: only word
    // transfers are issued, and the 4 KB window aliases upward
    wire unused_bus;

    assign unused_bus = ^{HSIZE, HADDR[31:12], HADDR[1:0], HTRANS[0]};

endmodule : tpc_config_regs

// ===== logic/tpc_prbs7_gen.sv
// Seven-bit pseudo-random bit sequence generator for link quality tests
module tpc_prbs7_gen
    import tpc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic hold,
    output logic bit_out
);

    // Shift register state
    logic [6:0] lfsr;
    // Feedback bit
    logic feedback;
    // Running only when enabled and the transmitter is out of reset
    logic run;

    assign feedback = lfsr[PRBS_TAP_HI] ^ lfsr[PRBS_TAP_LO];
    assign run = enable & ~hold;

    // Advance one bit per clock; reseed when idle so each run starts alike
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lfsr <= PRBS_SEED;
            bit_out <= 1'b0;
        end else if (run) begin
            lfsr <= {lfsr[5:0], feedback};
            bit_out <= lfsr[PRBS_TAP_HI];
        end else begin
            // Disabled or held in reset: lfsr reseeded, output parked low
            lfsr <= PRBS_SEED;
            bit_out <= 1'b0;
        end
    end

endmodule : tpc_prbs7_gen

// ===== verif/tb.sv
// Self-checking bench for the config register bank
module tb
    import tpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Offsets in storage order
    localparam logic [11:0] OFS_TAB [NUM_REGS] = '{OFS_LINE_START_WAIT, OFS_PHY_HOLD_RESET,
        OFS_TX_EMPHASIS_LANE0, OFS_TX_EMPHASIS_LANE1, OFS_TX_EMPHASIS_LANE2,
        OFS_TX_EMPHASIS_LANE3, OFS_TX_SWING_LANE0, OFS_TX_SWING_LANE1, OFS_TX_SWING_LANE2,
        OFS_TX_SWING_LANE3, OFS_PRBS_TEST_PATTERN_ENABLE};
    localparam logic [7:0] WAITS [4] = '{8'h0, 8'h1, 8'h40, 8'hff}; // Edge and usual waits
    logic ref_clk = 1'b0; // 250 MHz core clock
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic line_start = 1'b0;
    logic hready; // Slave ready fed back
    logic [31:0] hrdata;
    logic hresp;
    logic busy;
    logic go;
    logic hold;
    logic prbs_on;
    logic prbs_bit;
    logic [2:0] emph [4];
    logic [2:0] swing [4];
    logic [15:0] prbs_errs;
    logic [15:0] prbs_ones;
    logic [31:0] pat [NUM_REGS] = '{default: 32'h0}; // Expected register contents
    int error_cnt = 0;
    int num_checks = 0;
    always #2 ref_clk = ~ref_clk; // 4 ns period
    tpc_config_regs u_dut (
        .REF_CLK(ref_clk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HREADY(hready), .HWDATA(hwdata), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .LINE_START(line_start), .LINE_WAIT_BUSY(busy),
        .LINE_DATA_GO(go), .TRANSMITTER_HOLD_IN_RESET(hold),
        .LANE0_EMPHASIS_LEVEL(emph[0]), .LANE1_EMPHASIS_LEVEL(emph[1]),
        .LANE2_EMPHASIS_LEVEL(emph[2]), .LANE3_EMPHASIS_LEVEL(emph[3]),
        .LANE0_SWING_LEVEL(swing[0]), .LANE1_SWING_LEVEL(swing[1]),
        .LANE2_SWING_LEVEL(swing[2]), .LANE3_SWING_LEVEL(swing[3]),
        .PRBS_TEST_PATTERN_ON(prbs_on), .PRBS_BIT(prbs_bit)
    );
    tpc_phy_model u_phy (.clk(ref_clk), .rst_n(reset_n), .hold(hold), .pattern_on(prbs_on),
        .serial_bit(prbs_bit), .err_cnt(prbs_errs), .one_cnt(prbs_ones));
    // Compare and count
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word
    // One single transfer; entered just after a rising edge
    task automatic bus(input logic wr, input logic [11:0] ofs, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {20'h0, ofs};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
    endtask : bus
    // Write then read one word back to back; the read rides the write's data phase
    task automatic wr_rd_chk(input string what, input logic [11:0] ofs, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, ofs};
        hwrite <= 1'b1;
        htrans <= 2'h2;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        hwrite <= 1'b0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= HTRANS_IDLE;
        hwdata <= 32'h0;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        chk_word(what, d, hrdata);
    endtask : wr_rd_chk
    task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
        logic [31:0] unused;
        bus(1'b1, ofs, d, unused);
    endtask : wr
    task automatic rd_chk(input string what, input logic [11:0] ofs, input logic [31:0] exp);
        logic [31:0] got;
        bus(1'b0, ofs, 32'h0, got);
        chk_word(what, exp, got);
    endtask : rd_chk
    // Lane, hold and pattern outputs against expected contents
    task automatic chk_outputs();
        for (int i = 0; i < 4; i++) begin
            chk_word("emphasis level", pat[2 + i] & 32'h7, {29'h0, emph[i]});
            chk_word("swing level", pat[6 + i] & 32'h7, {29'h0, swing[i]});
        end
        chk_word("hold output", pat[1] & 32'h1, {31'h0, hold});
        chk_word("pattern enable", pat[10] & 32'h1, {31'h0, prbs_on});
    endtask : chk_outputs
    task automatic tally_and_finish();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    // Hang guard, far above the expected run
    initial begin
        repeat (5000) @(posedge ref_clk);
        error_cnt++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        int n;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        foreach (OFS_TAB[i]) rd_chk("reset value", OFS_TAB[i], REG_RESET);
        chk_outputs();
        wr(12'h204, 32'hffffffff);
        rd_chk("unmapped read", 12'h204, 32'h0);
        // Write then read straight back, all 32 bits
        foreach (OFS_TAB[i]) begin
            pat[i] = 32'h13579bd0 ^ (i * 32'h01020305);
            wr(OFS_TAB[i], pat[i]);
            rd_chk("readback", OFS_TAB[i], pat[i]);
        end
        chk_outputs();
        // Read in the write's data phase must see the new word
        wr_rd_chk("forwarded read", OFS_TX_SWING_LANE1, 32'ha5c3e187);
        // Busy length per wait, upper bits must not count
        foreach (WAITS[k]) begin
            wr(OFS_LINE_START_WAIT, {24'hc0ffee, WAITS[k]});
            line_start <= 1'b1;
            @(posedge ref_clk);
            line_start <= 1'b0;
            n = 0;
            #1;
            while (busy === 1'b1 && n < 300) begin
                n++;
                @(posedge ref_clk);
                #1;
            end
            chk_word("busy cycles", 32'(WAITS[k]), 32'(n));
            chk_word("data go", 32'h1, {31'h0, go});
            @(posedge ref_clk);
        end
        // A new line in mid-wait restarts the full count of 255
        line_start <= 1'b1;
        @(posedge ref_clk);
        line_start <= 1'b0;
        repeat (3) @(posedge ref_clk);
        line_start <= 1'b1;
        @(posedge ref_clk);
        line_start <= 1'b0;
        repeat (254) @(posedge ref_clk);
        #1;
        chk_word("restarted busy", 32'h1, {31'h0, busy});
        @(posedge ref_clk);
        #1;
        chk_word("restarted go", 32'h1, {31'h0, go});
        @(posedge ref_clk);
        wr(OFS_PHY_HOLD_RESET, 32'h0);
        wr(OFS_PRBS_TEST_PATTERN_ENABLE, 32'h1);
        repeat (140) @(posedge ref_clk);
        chk_word("pattern errors", 32'h0, {16'h0, prbs_errs});
        chk_word("pattern alive", 32'h1, {31'h0, prbs_ones > 16'h0});
        wr(OFS_PHY_HOLD_RESET, 32'h1);
        repeat (2) @(posedge ref_clk);
        chk_word("held pattern bit", 32'h0, {31'h0, prbs_bit});
        // Second reset in mid-run clears contents
        reset_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd_chk("value after reset", OFS_TX_SWING_LANE2, REG_RESET);
        tally_and_finish();
    end
endmodule : tb

// ===== verif/tpc_phy_model.sv
// Lane transmitter model that judges the serial test pattern
module tpc_phy_model
    import tpc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hold,
    input wire logic pattern_on,
    input wire logic serial_bit,
    output logic [15:0] err_cnt,
    output logic [15:0] one_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] hist; // Last seven bits seen
    logic [3:0] run; // Bits since pattern start
    wire live = pattern_on && !hold; // Lanes send the pattern
    wire predict = hist[6] ^ hist[5]; // Recurrence of x^7 + x^6 + 1
    // Self-synchronising, so start-up latency is not assumed
    wire judge = live && run == 4'h9;
    // Receive and judge one bit per cycle
    always_ff @(posedge clk) begin
        hist <= {hist[5:0], serial_bit};
        run <= !live ? 4'h0 : run + 4'(run != 4'h9);
        if (!rst_n) begin
            err_cnt <= 16'h0;
            one_cnt <= 16'h0;
        end else if (judge) begin
            err_cnt <= err_cnt + 16'(serial_bit !== predict);
            one_cnt <= one_cnt + 16'(serial_bit);
        end
    end
endmodule : tpc_phy_model

// ===== verif/tpc_regs_chk.sv
// Bus and output checks for the config register bank
module tpc_regs_chk
    import tpc_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HWDATA,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic LINE_START,
    input wire logic LINE_WAIT_BUSY,
    input wire logic LINE_DATA_GO,
    input wire logic TRANSMITTER_HOLD_IN_RESET,
    input wire logic [2:0] LANE0_EMPHASIS_LEVEL,
    input wire logic [2:0] LANE1_SWING_LEVEL,
    input wire logic PRBS_TEST_PATTERN_ON,
    input wire logic PRBS_BIT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESET_N);
    logic wr_q; // Write data phase
    logic rd_q; // Read data phase
    logic [11:0] ofs_q; // Offset of data phase
    logic [7:0] wait_q; // Shadow of line wait
    logic [7:0] left; // Busy cycles still due
    logic go_q; // Go pulse due
    wire taken = HSEL && HREADY && HTRANS[1];
    wire wait_wr = wr_q && ofs_q == OFS_LINE_START_WAIT;
    // A new line restarts the count
    wire [7:0] next_left = LINE_START ? wait_q : left - 8'(left != 8'h0);
    // Shadow of bus phases and line wait
    always_ff @(posedge REF_CLK) begin
        if (!RESET_N) begin
            {wr_q, rd_q, ofs_q, wait_q, left, go_q} <= 31'h0;
        end else begin
            wr_q <= taken && HWRITE;
            rd_q <= taken && !HWRITE;
            ofs_q <= HADDR[11:0];
            wait_q <= wait_wr ? HWDATA[7:0] : wait_q;
            left <= next_left;
            go_q <= LINE_START ? wait_q == 8'h0 : left == 8'h1;
        end
    end
    bus_okay_a: assert property (HREADYOUT && HRESP == HRESP_OKAY)
        else $error("bus stalled or errored");
    rdata_park_a: assert property (!rd_q |-> HRDATA == 32'h0)
        else $error("read data outside read phase");
    hold_write_a: assert property (wr_q && ofs_q == OFS_PHY_HOLD_RESET
        |=> TRANSMITTER_HOLD_IN_RESET == $past(HWDATA[HOLD_BIT])) else $error("hold bit lost");
    emph_write_a: assert property (wr_q && ofs_q == OFS_TX_EMPHASIS_LANE0
        |=> LANE0_EMPHASIS_LEVEL == $past(HWDATA[2:0])) else $error("emphasis code altered");
    swing_read_a: assert property (rd_q && ofs_q == OFS_TX_SWING_LANE1
        |-> HRDATA[2:0] == LANE1_SWING_LEVEL) else $error("swing readback differs");
    prbs_write_a: assert property (wr_q && ofs_q == OFS_PRBS_TEST_PATTERN_ENABLE
        |=> PRBS_TEST_PATTERN_ON == $past(HWDATA[0])) else $error("pattern enable lost");
    busy_count_a: assert property (LINE_WAIT_BUSY == (left != 8'h0))
        else $error("line wait length wrong");
    go_pulse_a: assert property (LINE_DATA_GO == go_q)
        else $error("go pulse misplaced");
    prbs_quiet_a: assert property ((!PRBS_TEST_PATTERN_ON || TRANSMITTER_HOLD_IN_RESET)[*2]
        |-> !PRBS_BIT) else $error("pattern bit while stopped");
    // Main scenarios reached
    cover property (LINE_WAIT_BUSY ##1 LINE_DATA_GO);
    cover property (rd_q && HRDATA != 32'h0);
    cover property (PRBS_BIT);
endmodule : tpc_regs_chk

bind tpc_config_regs tpc_regs_chk u_chk (.*);
